// ===== pptl_consts.svh
// Offsets, field positions, reset values and timing figures of the power/test/indicator bank.
// Assumes a 100 MHz core clock; register offsets are word indices, byte address = 4 * index.
`ifndef PPTL_CONSTS_SVH
`define PPTL_CONSTS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define PPTL_IDX_DPD        12'h428
`define PPTL_IDX_EQ         12'h450
`define PPTL_IDX_GAP        12'h456
`define PPTL_IDX_LED        12'h460
`define PPTL_IDX_IRQ_STAT   12'h470
`define PPTL_IDX_IRQ_MASK   12'h471

// ==========================================================
// Reset values and writable-bit masks
`define PPTL_RST_DPD        16'h0000
`define PPTL_RST_EQ         16'h0141
`define PPTL_RST_GAP        16'h0008
`define PPTL_RST_LED        16'h0551
`define PPTL_RST_IRQ_MASK   3'h0
`define PPTL_WMASK_DPD      16'h003f
`define PPTL_WMASK_EQ       16'hffff
`define PPTL_WMASK_GAP      16'hffff
`define PPTL_WMASK_LED      16'h0fff

// ==========================================================
// Field positions
`define PPTL_DPD_MSB_BIT    5
`define PPTL_DPD_TEST_BIT   4
`define PPTL_DPD_SPEED_BIT  3
`define PPTL_DPD_EN_BIT     2
`define PPTL_EQ_BYP_BIT     13
`define PPTL_GAP_MIN_BIT    3
`define PPTL_LED1_LSB       8
`define PPTL_LED3_LSB       4
`define PPTL_IRQ_LINK_BIT   0
`define PPTL_IRQ_PRBS_BIT   1
`define PPTL_IRQ_DPD_BIT    2
`define PPTL_STAT_SLEEP_BIT 4
`define PPTL_STAT_EXIT_BIT  5
`define PPTL_STAT_SPD_BIT   6
`define PPTL_PIN_FUNC_LED3  3'h1

// ==========================================================
// Timing figures in their own units
`define PPTL_CLK_MHZ        100
`define PPTL_DPD_FAST_MS    50
`define PPTL_DPD_SLOW_MS    100
`define PPTL_IPG_MIN_NS     120
`define PPTL_IPG_STD_NS     200
`define PPTL_BLINK_MS       50

`endif

// ===== pptl_pkg.sv
// Types shared by the power/test/indicator bank.
// Assumes pptl_consts.svh supplies every number.
package pptl_pkg;

  // ==========================================================
  // Indicator source codes
  typedef enum logic [3:0] {
    PPTL_LED_LINK      = 4'h0,
    PPTL_LED_ACT       = 4'h1,
    PPTL_LED_TX        = 4'h2,
    PPTL_LED_RX        = 4'h3,
    PPTL_LED_COL       = 4'h4,
    PPTL_LED_SPD100    = 4'h5,
    PPTL_LED_SPD10     = 4'h6,
    PPTL_LED_FDX       = 4'h7,
    PPTL_LED_LINKBLINK = 4'h8,
    PPTL_LED_STRETCH   = 4'h9,
    PPTL_LED_LINK100FD = 4'ha,
    PPTL_LED_LPI       = 4'hb,
    PPTL_LED_ERR       = 4'hc,
    PPTL_LED_LOST      = 4'hd,
    PPTL_LED_PRBS      = 4'he,
    PPTL_LED_RSVD      = 4'hf
  } pptl_led_e;

  // ==========================================================
  // Deep power down sequencer, Gray along run -> sleep -> exit
  typedef enum logic [1:0] {
    PPTL_DPD_RUN   = 2'h0,
    PPTL_DPD_SLEEP = 2'h1,
    PPTL_DPD_EXIT  = 2'h3
  } pptl_dpd_e;

endpackage

// ===== pptl_idle_gen.sv
// Idle-pattern test generator: a one followed by a programmed run of zeros, one bit per clock.
// Assumes enable and run length come from registers on the same clock.
`timescale 1ns/1ps
module pptl_idle_gen (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_enable,
  input  wire logic [4:0] i_zero_run,
  output logic            o_bit
);

  logic [4:0] pos_q;
  logic       bit_q;
  logic [5:0] zeros_q;
  logic [5:0] cfg_age_q;

  assign o_bit = bit_q;

  // ==========================================================
  // Pattern position
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pos_q <= 5'h00;
      bit_q <= 1'b0;
    end else if (!i_enable || i_zero_run == 5'h00) begin
      pos_q <= 5'h00;
      bit_q <= 1'b0;
    end else begin
      bit_q <= (pos_q == 5'h00);
      pos_q <= (pos_q >= i_zero_run) ? 5'h00 : pos_q + 5'h01;
    end
  end

  // ==========================================================
  // Assertion helpers: zeros since the last one, cycles since config changed
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      zeros_q   <= 6'h00;
      cfg_age_q <= 6'h00;
    end else begin
      zeros_q <= bit_q ? 6'h00 : zeros_q + 6'h01;
      if (!i_enable || $changed(i_zero_run)) begin
        cfg_age_q <= 6'h00;
      end else if (cfg_age_q != 6'h3f) begin
        cfg_age_q <= cfg_age_q + 6'h01;
      end
    end
  end

  property p_zero_run;
    @(posedge i_clk) disable iff (!i_arst_n)
      (bit_q && !$past(bit_q) && cfg_age_q > 6'h22) |-> (zeros_q == {1'b0, $past(i_zero_run)});
  endproperty
  a_zero_run: assert property (p_zero_run) else $error("zero run length wrong");

  property p_clear;
    @(posedge i_clk) disable iff (!i_arst_n)
      (i_zero_run == 5'h00) |=> (!bit_q && pos_q == 5'h00);
  endproperty
  a_clear: assert property (p_clear) else $error("pattern not cleared");

  property p_cov_run;
    @(posedge i_clk) disable iff (!i_arst_n)
      i_enable && bit_q && i_zero_run == 5'h1f;
  endproperty
  c_cov_run: cover property (p_cov_run);

endmodule

// ===== pptl_regs.sv
// Power-down, idle-test, equalizer, gap and indicator configuration bank with APB slave.
// Assumes status inputs come from PHY logic on I_CLK; only the power-down pin is asynchronous.
`timescale 1ns/1ps
`include "pptl_consts.svh"

module pptl_regs #(
  parameter int unsigned P_DPD_FAST_CYC = `PPTL_DPD_FAST_MS * 1000 * `PPTL_CLK_MHZ,
  parameter int unsigned P_DPD_SLOW_CYC = `PPTL_DPD_SLOW_MS * 1000 * `PPTL_CLK_MHZ,
  parameter int unsigned P_BLINK_CYC    = `PPTL_BLINK_MS * 1000 * `PPTL_CLK_MHZ
) (
  input  wire logic        I_CLK,
  input  wire logic        I_ARST_N,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [15:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic [3:0]  I_TEST_MODE_LOW,
  input  wire logic        I_IEEE_PWRDN,
  input  wire logic        I_INTERRUPT_POWERDOWN_PIN,
  input  wire logic        I_LINK_OK,
  input  wire logic        I_TX_ACT,
  input  wire logic        I_RX_ACT,
  input  wire logic        I_COL,
  input  wire logic        I_SPEED100,
  input  wire logic        I_FULL_DUPLEX,
  input  wire logic        I_LPI,
  input  wire logic        I_MII_ERR,
  input  wire logic        I_PRBS_ERR,
  input  wire logic        I_BASIC_CTRL_RD,
  input  wire logic        I_SELF_TEST_CLR,
  input  wire logic [2:0]  I_PIN_FUNC_SEL,
  input  wire logic        I_RECEIVE_BIT3_ALT,
  output logic             O_IDLE_TEST_ACTIVE,
  output logic             O_IDLE_TEST_BIT,
  output logic             O_DEEP_POWER_DOWN,
  output logic             O_DPD_EXITING,
  output logic             O_EQ_CAL_BYPASS,
  output logic      [4:0]  O_IPG_CYCLES,
  output logic             O_FIRST_INDICATOR,
  output logic             O_RECEIVE_BIT3_PIN,
  output logic             O_IRQ
);

  localparam logic [4:0] IPG_MIN_CYC = 5'((`PPTL_IPG_MIN_NS * `PPTL_CLK_MHZ + 999) / 1000);
  localparam logic [4:0] IPG_STD_CYC = 5'((`PPTL_IPG_STD_NS * `PPTL_CLK_MHZ + 999) / 1000);
  localparam int         BLINK_W     = $clog2(P_BLINK_CYC + 1);

  // ==========================================================
  // Declarations
  logic [15:0]          dpd_q, eq_q, gap_q, led_q;
  logic [2:0]           stat_q, stat_d, mask_q, events;
  logic                 pready_q, pslverr_q;
  logic [31:0]          prdata_q, rdata_d;
  logic                 hit_d, setup, wr_en;
  logic                 pd_pin_s1_q, pd_pin_s2_q;
  pptl_pkg::pptl_dpd_e  state_q, state_d;
  logic [23:0]          exit_cnt_q;
  logic                 exit_fast_q, dpd_done;
  logic [BLINK_W-1:0]   blink_cnt_q;
  logic                 tick, blink_q, act_seen_q, stretch_q;
  logic                 link_prev_q, lost_q, prbs_q;
  logic [15:0]          srcs;
  logic                 led3_val;
  logic                 first_q, rxd3_q, irq_q, sleep_q, exiting_q, byp_q;
  logic [4:0]           ipg_q;

  function automatic logic is_idx(input logic [15:0] addr, input logic [11:0] idx);
    return addr == {2'b00, idx, 2'b00};
  endfunction

  // Code 1111 maps to the constant-zero top bit of the source vector
  function automatic logic led_pick(input logic [3:0] code, input logic [15:0] src);
    return src[code];
  endfunction

  // ==========================================================
  // APB slave: answers in the first access cycle
  assign setup = I_PSEL && !I_PENABLE;
  assign wr_en = I_PSEL && I_PENABLE && pready_q && I_PWRITE && hit_d;

  always_comb begin
    hit_d   = 1'b1;
    rdata_d = 32'h0000_0000;
    if (is_idx(I_PADDR, `PPTL_IDX_DPD)) begin
      rdata_d[15:0] = dpd_q;
    end else if (is_idx(I_PADDR, `PPTL_IDX_EQ)) begin
      rdata_d[15:0] = eq_q;
    end else if (is_idx(I_PADDR, `PPTL_IDX_GAP)) begin
      rdata_d[15:0] = gap_q;
    end else if (is_idx(I_PADDR, `PPTL_IDX_LED)) begin
      rdata_d[15:0] = led_q;
    end else if (is_idx(I_PADDR, `PPTL_IDX_IRQ_STAT)) begin
      rdata_d[2:0]                    = stat_q;
      rdata_d[`PPTL_STAT_SLEEP_BIT]   = sleep_q;
      rdata_d[`PPTL_STAT_EXIT_BIT]    = exiting_q;
      rdata_d[`PPTL_STAT_SPD_BIT]     = I_IEEE_PWRDN || pd_pin_s2_q;
    end else if (is_idx(I_PADDR, `PPTL_IDX_IRQ_MASK)) begin
      rdata_d[2:0] = mask_q;
    end else begin
      hit_d = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !hit_d;
      prdata_q  <= (setup && !I_PWRITE) ? rdata_d : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Configuration registers; read-only reserved bits never take writes
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      dpd_q  <= `PPTL_RST_DPD;
      eq_q   <= `PPTL_RST_EQ;
      gap_q  <= `PPTL_RST_GAP;
      led_q  <= `PPTL_RST_LED;
      mask_q <= `PPTL_RST_IRQ_MASK;
    end else if (wr_en) begin
      if (is_idx(I_PADDR, `PPTL_IDX_DPD)) begin
        dpd_q <= I_PWDATA[15:0] & `PPTL_WMASK_DPD;
      end
      if (is_idx(I_PADDR, `PPTL_IDX_EQ)) begin
        eq_q <= I_PWDATA[15:0] & `PPTL_WMASK_EQ;
      end
      if (is_idx(I_PADDR, `PPTL_IDX_GAP)) begin
        gap_q <= I_PWDATA[15:0] & `PPTL_WMASK_GAP;
      end
      if (is_idx(I_PADDR, `PPTL_IDX_LED)) begin
        led_q <= I_PWDATA[15:0] & `PPTL_WMASK_LED;
      end
      if (is_idx(I_PADDR, `PPTL_IDX_IRQ_MASK)) begin
        mask_q <= I_PWDATA[2:0];
      end
    end
  end

  // ==========================================================
  // Interrupt status: write one to clear, a new event wins over the clear
  assign events[`PPTL_IRQ_LINK_BIT] = link_prev_q && !I_LINK_OK;
  assign events[`PPTL_IRQ_PRBS_BIT] = I_PRBS_ERR;
  assign events[`PPTL_IRQ_DPD_BIT]  = dpd_done;

  always_comb begin
    stat_d = stat_q;
    if (wr_en && is_idx(I_PADDR, `PPTL_IDX_IRQ_STAT)) begin
      stat_d = stat_q & ~I_PWDATA[2:0];
    end
    stat_d = stat_d | events;
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      stat_q <= 3'h0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q  <= |(stat_d & mask_q);
    end
  end

  // ==========================================================
  // Power-down pin synchroniser, shown in status only
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pd_pin_s1_q <= 1'b0;
      pd_pin_s2_q <= 1'b0;
    end else begin
      pd_pin_s1_q <= I_INTERRUPT_POWERDOWN_PIN;
      pd_pin_s2_q <= pd_pin_s1_q;
    end
  end

  // ==========================================================
  // Deep power down sequencer; exit time is fixed when the exit starts
  always_comb begin
    state_d  = state_q;
    dpd_done = 1'b0;
    unique case (state_q)
      pptl_pkg::PPTL_DPD_RUN: begin
        if (dpd_q[`PPTL_DPD_EN_BIT]) state_d = pptl_pkg::PPTL_DPD_SLEEP;
      end
      pptl_pkg::PPTL_DPD_SLEEP: begin
        if (!dpd_q[`PPTL_DPD_EN_BIT]) state_d = pptl_pkg::PPTL_DPD_EXIT;
      end
      pptl_pkg::PPTL_DPD_EXIT: begin
        if (exit_cnt_q == 24'h00_0000) begin
          state_d  = pptl_pkg::PPTL_DPD_RUN;
          dpd_done = 1'b1;
        end
      end
      default: state_d = pptl_pkg::PPTL_DPD_RUN;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_q     <= pptl_pkg::PPTL_DPD_RUN;
      exit_cnt_q  <= 24'h00_0000;
      exit_fast_q <= 1'b0;
      sleep_q     <= 1'b0;
      exiting_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      sleep_q   <= (state_d == pptl_pkg::PPTL_DPD_SLEEP);
      exiting_q <= (state_d == pptl_pkg::PPTL_DPD_EXIT);
      if (state_q == pptl_pkg::PPTL_DPD_SLEEP && state_d == pptl_pkg::PPTL_DPD_EXIT) begin
        exit_fast_q <= dpd_q[`PPTL_DPD_SPEED_BIT];
        exit_cnt_q  <= dpd_q[`PPTL_DPD_SPEED_BIT] ? 24'(P_DPD_FAST_CYC - 1)
                                                  : 24'(P_DPD_SLOW_CYC - 1);
      end else if (exit_cnt_q != 24'h00_0000) begin
        exit_cnt_q <= exit_cnt_q - 24'h00_0001;
      end
    end
  end

  // ==========================================================
  // Idle-pattern generator
  pptl_idle_gen pptl_idle_gen_inst (
    .i_clk      (I_CLK),
    .i_arst_n   (I_ARST_N),
    .i_enable   (dpd_q[`PPTL_DPD_TEST_BIT]),
    .i_zero_run ({dpd_q[`PPTL_DPD_MSB_BIT], I_TEST_MODE_LOW}),
    .o_bit      (O_IDLE_TEST_BIT)
  );

  // ==========================================================
  // Blink and activity-stretch time base
  assign tick = (blink_cnt_q == BLINK_W'(P_BLINK_CYC - 1));

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
      act_seen_q  <= 1'b0;
      stretch_q   <= 1'b0;
    end else begin
      blink_cnt_q <= tick ? '0 : blink_cnt_q + BLINK_W'(1);
      if (tick) begin
        blink_q    <= !blink_q;
        stretch_q  <= act_seen_q || I_TX_ACT || I_RX_ACT;
        act_seen_q <= 1'b0;
      end else if (I_TX_ACT || I_RX_ACT) begin
        act_seen_q <= 1'b1;
        stretch_q  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Latched indicator sources; a new event wins over its clear
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      link_prev_q <= 1'b0;
      lost_q      <= 1'b0;
      prbs_q      <= 1'b0;
    end else begin
      link_prev_q <= I_LINK_OK;
      if (link_prev_q && !I_LINK_OK) begin
        lost_q <= 1'b1;
      end else if (I_BASIC_CTRL_RD) begin
        lost_q <= 1'b0;
      end
      if (I_PRBS_ERR) begin
        prbs_q <= 1'b1;
      end else if (I_SELF_TEST_CLR) begin
        prbs_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Indicator multiplexers
  always_comb begin
    srcs     = 16'h0000;
    srcs[0]  = I_LINK_OK;
    srcs[1]  = I_TX_ACT || I_RX_ACT;
    srcs[2]  = I_TX_ACT;
    srcs[3]  = I_RX_ACT;
    srcs[4]  = I_COL;
    srcs[5]  = I_SPEED100;
    srcs[6]  = !I_SPEED100;
    srcs[7]  = I_FULL_DUPLEX;
    srcs[8]  = I_LINK_OK && !(stretch_q && blink_q);
    srcs[9]  = stretch_q;
    srcs[10] = I_LINK_OK && I_SPEED100 && I_FULL_DUPLEX;
    srcs[11] = I_LPI;
    srcs[12] = I_MII_ERR;
    srcs[13] = lost_q;
    srcs[14] = prbs_q;
  end

  assign led3_val = led_pick(led_q[`PPTL_LED3_LSB +: 4], srcs);

  // ==========================================================
  // Output flops
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      first_q <= 1'b0;
      rxd3_q  <= 1'b0;
      byp_q   <= 1'b0;
      ipg_q   <= IPG_MIN_CYC;
    end else begin
      first_q <= led_pick(led_q[`PPTL_LED1_LSB +: 4], srcs);
      rxd3_q  <= (I_PIN_FUNC_SEL == `PPTL_PIN_FUNC_LED3) ? led3_val : I_RECEIVE_BIT3_ALT;
      byp_q   <= eq_q[`PPTL_EQ_BYP_BIT];
      ipg_q   <= gap_q[`PPTL_GAP_MIN_BIT] ? IPG_MIN_CYC : IPG_STD_CYC;
    end
  end

  assign O_PRDATA           = prdata_q;
  assign O_PREADY           = pready_q;
  assign O_PSLVERR          = pslverr_q;
  assign O_IDLE_TEST_ACTIVE = dpd_q[`PPTL_DPD_TEST_BIT];
  assign O_DEEP_POWER_DOWN  = sleep_q;
  assign O_DPD_EXITING      = exiting_q;
  assign O_EQ_CAL_BYPASS    = byp_q;
  assign O_IPG_CYCLES       = ipg_q;
  assign O_FIRST_INDICATOR  = first_q;
  assign O_RECEIVE_BIT3_PIN = rxd3_q;
  assign O_IRQ              = irq_q;

  // ==========================================================
  // Assertions
  logic [23:0] exit_len_q;
  logic        wr_dpd, wr_eq;
  assign wr_dpd = wr_en && is_idx(I_PADDR, `PPTL_IDX_DPD);
  assign wr_eq  = wr_en && is_idx(I_PADDR, `PPTL_IDX_EQ);

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) exit_len_q <= 24'h00_0000;
    else exit_len_q <= exiting_q ? exit_len_q + 24'h00_0001 : 24'h00_0000;
  end

  property p_idle_en;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      wr_dpd |=> (O_IDLE_TEST_ACTIVE == $past(I_PWDATA[`PPTL_DPD_TEST_BIT]));
  endproperty
  a_idle_en: assert property (p_idle_en) else $error("idle test enable not applied");

  property p_exit_len;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      $fell(exiting_q) |-> (exit_len_q == (exit_fast_q ? 24'(P_DPD_FAST_CYC)
                                                        : 24'(P_DPD_SLOW_CYC)));
  endproperty
  a_exit_len: assert property (p_exit_len) else $error("deep power down exit time wrong");

  property p_dpd_enter;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      (state_q == pptl_pkg::PPTL_DPD_RUN && dpd_q[`PPTL_DPD_EN_BIT]) |=> O_DEEP_POWER_DOWN;
  endproperty
  a_dpd_enter: assert property (p_dpd_enter) else $error("deep power down not entered");

  property p_eq_byp;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      wr_eq |=> ##1 (O_EQ_CAL_BYPASS == $past(I_PWDATA[`PPTL_EQ_BYP_BIT], 2));
  endproperty
  a_eq_byp: assert property (p_eq_byp) else $error("equalizer bypass not applied");

  property p_ipg;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      ##1 (O_IPG_CYCLES == ($past(gap_q[`PPTL_GAP_MIN_BIT]) ? 5'h0c : 5'h14));
  endproperty
  a_ipg: assert property (p_ipg) else $error("gap length wrong");

  property p_led1_rsvd;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      (led_q[`PPTL_LED1_LSB +: 4] == pptl_pkg::PPTL_LED_RSVD) |=> !O_FIRST_INDICATOR;
  endproperty
  a_led1_rsvd: assert property (p_led1_rsvd) else $error("reserved source lit");

  property p_lost_hold;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      (lost_q && !I_BASIC_CTRL_RD) |=> lost_q;
  endproperty
  a_lost_hold: assert property (p_lost_hold) else $error("link lost latch dropped");

  property p_prbs_set;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      I_PRBS_ERR |=> prbs_q;
  endproperty
  a_prbs_set: assert property (p_prbs_set) else $error("sequence error not latched");

  property p_pin_alt;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      (I_PIN_FUNC_SEL != `PPTL_PIN_FUNC_LED3) |=> (O_RECEIVE_BIT3_PIN == $past(I_RECEIVE_BIT3_ALT));
  endproperty
  a_pin_alt: assert property (p_pin_alt) else $error("pin carries indicator wrongly");

  property p_rsvd_read;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      (setup && !I_PWRITE && is_idx(I_PADDR, `PPTL_IDX_LED)) |=> (O_PRDATA[31:12] == 20'h00000);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits read nonzero");

  property p_cov_exit;
    @(posedge I_CLK) disable iff (!I_ARST_N) dpd_done;
  endproperty
  c_cov_exit: cover property (p_cov_exit);

  property p_cov_lost;
    @(posedge I_CLK) disable iff (!I_ARST_N)
      O_FIRST_INDICATOR && led_q[`PPTL_LED1_LSB +: 4] == pptl_pkg::PPTL_LED_LOST;
  endproperty
  c_cov_lost: cover property (p_cov_lost);

  property p_cov_err;
    @(posedge I_CLK) disable iff (!I_ARST_N) O_PSLVERR && O_PREADY;
  endproperty
  c_cov_err: cover property (p_cov_err);

endmodule

// ===== pptl_regs_tb_top.sv
// Self-checking bench for the power, idle-test and indicator register bank.
// Assumes pptl_regs with zero-wait APB and shortened exit and blink counts.
`timescale 1ns/1ps
`include "pptl_consts.svh"
module pptl_regs_tb_top;
  // ==========================================================
  // Signals
  localparam logic [15:0] A_DPD = {2'h0, `PPTL_IDX_DPD, 2'h0};
  localparam logic [15:0] A_EQ  = {2'h0, `PPTL_IDX_EQ, 2'h0};
  localparam logic [15:0] A_GAP = {2'h0, `PPTL_IDX_GAP, 2'h0};
  localparam logic [15:0] A_LED = {2'h0, `PPTL_IDX_LED, 2'h0};
  localparam logic [15:0] A_STA = {2'h0, `PPTL_IDX_IRQ_STAT, 2'h0};
  localparam logic [15:0] A_MSK = {2'h0, `PPTL_IDX_IRQ_MASK, 2'h0};
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, e;
  logic [15:0] pa = 0;
  logic [31:0] pwd = 0, prd, r;
  logic [3:0]  tml = 0;
  logic [2:0]  pf = 0;
  logic pwdn = 0, pin = 0, link = 0, tx = 0, rx = 0, col = 0, s100 = 0, fdx = 0;
  logic lpi = 0, merr = 0, perr = 0, bcr = 0, stc = 0, alt = 0;
  logic prdy, pslv, act, ibit, dpdo, exo, eqo, ind1, rxp, irq;
  logic [4:0]  ipg;
  int errors = 0, n_checks = 0, cyc = 0, i;
  pptl_regs #(.P_DPD_FAST_CYC(50), .P_DPD_SLOW_CYC(100), .P_BLINK_CYC(8)) pptl_regs_inst (
    .I_CLK(clk), .I_ARST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(pslv),
    .I_TEST_MODE_LOW(tml), .I_IEEE_PWRDN(pwdn), .I_INTERRUPT_POWERDOWN_PIN(pin),
    .I_LINK_OK(link), .I_TX_ACT(tx), .I_RX_ACT(rx), .I_COL(col), .I_SPEED100(s100),
    .I_FULL_DUPLEX(fdx), .I_LPI(lpi), .I_MII_ERR(merr), .I_PRBS_ERR(perr),
    .I_BASIC_CTRL_RD(bcr), .I_SELF_TEST_CLR(stc), .I_PIN_FUNC_SEL(pf),
    .I_RECEIVE_BIT3_ALT(alt), .O_IDLE_TEST_ACTIVE(act), .O_IDLE_TEST_BIT(ibit),
    .O_DEEP_POWER_DOWN(dpdo), .O_DPD_EXITING(exo), .O_EQ_CAL_BYPASS(eqo),
    .O_IPG_CYCLES(ipg), .O_FIRST_INDICATOR(ind1), .O_RECEIVE_BIT3_PIN(rxp), .O_IRQ(irq));
  always #5 clk = ~clk;
  // Hang guard, generous against the longest exit wait
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd;
    e = pslv;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk(r, x);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rc(A_DPD, 0);
    rc(A_EQ, 32'h141);
    rc(A_GAP, 32'h8);
    rc(A_LED, 32'h551);
    chk(ipg, 12);
    apb(1, A_DPD, 32'hffc0);
    rc(A_DPD, 0);
    apb(1, A_LED, 32'hf551);
    rc(A_LED, 32'h551);
    apb(1, A_EQ, 32'h2141);
    wt(2);
    chk(eqo, 1);
    apb(1, A_GAP, 0);
    wt(2);
    chk(ipg, 20);
    apb(1, A_GAP, 8);
    apb(0, 16'h1000, 32'h5);
    chk(e, 1);
    chk(r, 0);
  endtask
  task automatic t_pat(input logic [4:0] n);
    apb(1, A_DPD, 0);
    tml <= n[3:0];
    apb(1, A_DPD, {26'h0, n[4], 5'h10});
    wt(1);
    chk(act, 1);
    for (i = 0; ibit !== 1'b1 && i < 40; i++) @(posedge clk);
    for (i = 0; i < n + 2; i++) begin
      @(posedge clk);
      chk(ibit, n != 0 && i == n);
    end
    // Run on so the zero-run assertion sees whole periods
    wt(40);
  endtask
  task automatic t_dpd(input logic sp, input int n);
    pwdn <= 1;
    apb(1, A_DPD, {28'h0, sp, 3'h4});
    wt(3);
    chk(dpdo, 1);
    apb(1, A_DPD, {28'h0, sp, 3'h0});
    for (i = 0; exo !== 1'b1 && i < 10; i++) @(posedge clk);
    for (i = 0; exo === 1'b1 && i < 300; i++) @(posedge clk);
    chk(i, n);
    chk(dpdo, 0);
    pwdn <= 0;
  endtask
  task automatic t_led;
    for (int p = 0; p < 2; p++) begin
      {tx, rx, col, fdx, lpi, merr} <= {6{p[0]}};
      for (int c = 0; c < 16; c++) begin
        apb(1, A_LED, {20'h0, c[3:0], 8'h51});
        wt(3);
        chk(ind1, p ? (16'h1ade >> c) & 1 : c == 6);
      end
    end
    {tx, rx, col, fdx, lpi, merr} <= 0;
    apb(1, A_LED, 32'hd51);
    link <= 1;
    wt(3);
    link <= 0;
    wt(2);
    link <= 1;
    wt(3);
    chk(ind1, 1);
    bcr <= 1;
    wt(1);
    bcr <= 0;
    wt(3);
    chk(ind1, 0);
    apb(1, A_LED, 32'he51);
    perr <= 1;
    wt(1);
    perr <= 0;
    wt(5);
    chk(ind1, 1);
    stc <= 1;
    wt(1);
    stc <= 0;
    wt(3);
    chk(ind1, 0);
    s100 <= 1;
    pf <= 1;
    apb(1, A_LED, 32'h551);
    wt(3);
    chk(rxp, 1);
    apb(1, A_LED, 32'h561);
    wt(3);
    chk(rxp, 0);
    pf <= 0;
    alt <= 1;
    wt(3);
    chk(rxp, 1);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    wt(12);
    rst_n <= 1;
    t_regs;
    t_pat(1);
    t_pat(2);
    t_pat(16);
    t_pat(31);
    t_pat(0);
    apb(1, A_DPD, 0);
    wt(1);
    chk(act, 0);
    t_dpd(1, 50);
    chk(irq, 0);
    apb(1, A_MSK, 4);
    wt(2);
    chk(irq, 1);
    rc(A_STA, 32'h4);
    apb(1, A_STA, 4);
    wt(2);
    chk(irq, 0);
    pin <= 1;
    wt(3);
    rc(A_STA, 32'h40);
    pin <= 0;
    t_dpd(0, 100);
    chk(irq, 1);
    apb(1, A_STA, 7);
    apb(1, A_MSK, 0);
    t_led;
    results;
  end
endmodule
